// ===== verif/stbt_tap_ctrl.sv
`timescale 1ns/100ps
// ====================
// board test controller model
module stbt_tap_ctrl (
  // test access port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // tck stands low between frames, tms and tdi idle at their pull-up level
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 64 ns tck period, tdo read mid high phase
  task automatic tick(input logic m, input logic d, output logic o);
    #2 tms <= m;
    tdi <= d;
    #30 tck <= 1'b1;
    #16 o = tdo;
    #16 tck <= 1'b0;
  endtask

  // five tms-high clocks, then on to idle
  task automatic reset_walk();
    logic o;
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  // steer by tms, shift lsb first
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b1, o);
    if (ir)
      tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask
endmodule

// ===== verif/stbt_top_bench.sv
`timescale 1ns/100ps
// ====================
// transceiver bench
module stbt_top_bench;
  import stbt_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h5a3c_0e17;  // arbitrary value
  localparam logic [31:0] ST_RST = {17'h0, BCR_RESET, IR_RESET, 4'h0};
  logic             clk;
  logic             reset_n;
  logic [BUS_W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  stbt_ctl_t        hc;
  logic             tck, tms, tdi, tdo, tdo_oe;
  stbt_axi_req_t    req;
  stbt_axi_rsp_t    rsp;
  logic [63:0]      dout;
  logic [31:0]      rd;
  logic [1:0]       rs;
  int               bad_count;
  int               checks_done;

  stbt_top #(.ID_CODE(ID_VAL)) stbt_top_i (
    .clk(clk), .reset_n(reset_n), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
    .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .half_ctl(hc),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .axi_req(req), .axi_rsp(rsp));

  stbt_tap_ctrl stbt_tap_ctrl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ====================
  // tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [AXI_AW-1:0] ad, input logic [31:0] d,
                        output logic [1:0] r);
    logic ok;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= ad;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do
    begin
      @(negedge clk) ok = rsp.awready & rsp.wready;
      @(posedge clk);
    end
    while (!ok);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do
    begin
      @(negedge clk) ok = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk);
    end
    while (!ok);
    req.bready <= 1'b0;
    // let the release stand one edge before any next request
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [AXI_AW-1:0] ad, output logic [31:0] d,
                        output logic [1:0] r);
    logic ok;
    req.arvalid <= 1'b1;
    req.araddr <= ad;
    req.rready <= 1'b1;
    do
    begin
      @(negedge clk) ok = rsp.arready;
      @(posedge clk);
    end
    while (!ok);
    req.arvalid <= 1'b0;
    do
    begin
      @(negedge clk) ok = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk);
    end
    while (!ok);
    req.rready <= 1'b0;
    // let the release stand one edge before any next request
    @(posedge clk);
  endtask

  // ====================
  // tests
  initial
  begin
    reset_n = 1'b0;
    a_in = '0;
    b_in = '0;
    hc = {2{6'b110000}};
    req = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    axi_rd(ADDR_STATUS, rd, rs);
    chk("status", ST_RST, rd);
    stbt_tap_ctrl_i.reset_walk();
    stbt_tap_ctrl_i.scan(1'b0, 64'h0, 32, dout);
    chk("idcode", ID_VAL, dout[31:0]);
    // half 0 a to b transparent, half 1 b to a transparent
    hc[0].a_to_b_output_enable_n <= 1'b0;
    hc[0].a_to_b_latch_enable <= 1'b1;
    hc[1].b_to_a_output_enable_n <= 1'b0;
    hc[1].b_to_a_latch_enable <= 1'b1;
    a_in <= 18'h2a5a5;
    b_in <= 18'h1b36c;
    settle();
    chk("b_out", a_in[8:0], b_out[8:0]);
    chk("b_oe", 18'h001ff, b_oe);
    chk("a_out", b_in[17:9], a_out[17:9]);
    chk("a_oe", 18'h3fe00, a_oe);
    hc[0].a_to_b_latch_enable <= 1'b0;
    settle();
    a_in <= 18'h15a5a;
    settle();
    chk("b_hold", 9'h1a5, b_out[8:0]);
    hc[0].a_to_b_clock <= 1'b1;
    settle();
    chk("b_clocked", 9'h05a, b_out[8:0]);
    // pin snapshot and preload while data flows
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_SAMPLE}, 8, dout);
    chk("ir_capture", IR_RESET, dout[7:0]);
    stbt_tap_ctrl_i.scan(1'b0, {28'h0, 18'h1c3a5, 18'h0f0f0}, 48, dout);
    chk("snapshot", a_in[8:0], dout[8:0]);
    chk("flow", 9'h05a, b_out[8:0]);
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_EXTEST}, 8, dout);
    settle();
    chk("ext_b", 18'h1c3a5, b_out);
    chk("ext_a", 18'h0f0f0, a_out);
    chk("ext_oe", {2{18'h3ffff}}, {a_oe, b_oe});
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_HIGHZ}, 8, dout);
    settle();
    chk("highz", 36'h0, {a_oe, b_oe});
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_CLAMP}, 8, dout);
    settle();
    chk("clamp", 18'h1c3a5, b_out);
    stbt_tap_ctrl_i.scan(1'b0, 64'h3, 2, dout);
    chk("bypass", 2'b10, dout[1:0]);
    // odd parity opcode falls back to the one-bit path
    stbt_tap_ctrl_i.scan(1'b1, 64'h01, 8, dout);
    stbt_tap_ctrl_i.scan(1'b0, 64'h0a5, 9, dout);
    chk("odd_op", 9'h14a, dout[8:0]);
    stbt_tap_ctrl_i.reset_walk();
    settle();
    chk("normal", 9'h05a, b_out[8:0]);
    axi_rd(ADDR_STATUS, rd, rs);
    chk("status_rst", {ST_RST[31:4], 4'(TAP_IDLE)}, rd);
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_EXTEST}, 8, dout);
    settle();
    chk("rst_oe", 36'h0, {a_oe, b_oe});
    // software hold of the test logic
    axi_wr(ADDR_CTRL, 32'h1, rs);
    chk("ctrl_resp", RESP_OKAY, rs);
    settle();
    axi_rd(ADDR_STATUS, rd, rs);
    chk("held", ST_RST, rd);
    axi_wr(ADDR_CTRL, 32'h0, rs);
    axi_rd(12'h010, rd, rs);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {rs, rd});
    // boundary-control scan, then one binary count step in idle
    stbt_tap_ctrl_i.reset_walk();
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_BCRSC}, 8, dout);
    stbt_tap_ctrl_i.scan(1'b0, {61'h0, BC_COUNT}, 3, dout);
    chk("bcr_reset", BCR_RESET, dout[2:0]);
    stbt_tap_ctrl_i.scan(1'b1, {56'h0, OP_RUNT}, 8, dout);
    stbt_tap_ctrl_i.tick(1'b0, 1'b1, dout[0]);
    settle();
    chk("count", 18'h0f0f1, a_out);
    chk("count_b", 18'h1c3a5, b_out);
    finish_test();
  end

  // watchdog
  initial
  begin
    #300000;
    bad_count++;
    finish_test();
  end
endmodule

// ===== verilog/stbt_pkg.sv
package stbt_pkg;
  // ==========================================================
  // widths
  localparam int HALF_W    = 9;
  localparam int BUS_W     = 18;
  localparam int DATA_W    = 36;
  localparam int IR_W      = 8;
  localparam int BSR_W     = 48;
  localparam int BCR_W     = 3;
  localparam int ID_W      = 32;
  localparam int AXI_AW    = 12;
  // ==========================================================
  // boundary chain layout
  localparam int BSR_AB_OE = 46;  // b port enables, halves 1:0
  localparam int BSR_BA_OE = 44;  // a port enables, halves 1:0
  localparam int BSR_B_LSB = 18;
  localparam int LFSR_TAP  = 24;
  // ==========================================================
  // reset and capture values
  localparam logic [IR_W-1:0]  IR_RESET  = 8'h81;
  localparam logic [BCR_W-1:0] BCR_RESET = 3'h2;
  localparam logic [3:0]       OE_RESET  = 4'hf;
  localparam logic [2:0]       HI_CNT    = 3'h5;
  // ==========================================================
  // opcodes, all of even parity
  localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 8'h82;
  localparam logic [IR_W-1:0] OP_IDCODE = 8'h81;
  localparam logic [IR_W-1:0] OP_HIGHZ  = 8'h06;
  localparam logic [IR_W-1:0] OP_CLAMP  = 8'h87;
  localparam logic [IR_W-1:0] OP_RUNT   = 8'h09;
  localparam logic [IR_W-1:0] OP_BCRSC  = 8'h0a;
  localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;
  // boundary-control operations
  localparam logic [BCR_W-1:0] BC_TOGGLE = 3'h0;
  localparam logic [BCR_W-1:0] BC_PSEUDO_RANDOM_PATTERN_GEN   = 3'h1;
  localparam logic [BCR_W-1:0] BC_PSA    = 3'h2;
  localparam logic [BCR_W-1:0] BC_COUNT  = 3'h3;
  // ==========================================================
  // register map
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 12'h000;
  localparam logic [AXI_AW-1:0] ADDR_CTRL   = 12'h004;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SDR, TAP_CDR, TAP_SHDR, TAP_E1DR, TAP_PDR, TAP_E2DR,
    TAP_UDR, TAP_SIR, TAP_CIR, TAP_SHIR, TAP_E1IR, TAP_PIR, TAP_E2IR, TAP_UIR
  } stbt_tap_t;
  typedef struct packed {
    logic a_to_b_output_enable_n;
    logic b_to_a_output_enable_n;
    logic a_to_b_latch_enable;
    logic b_to_a_latch_enable;
    logic a_to_b_clock;
    logic b_to_a_clock;
  } stbt_half_ctl_t;
  typedef stbt_half_ctl_t [1:0] stbt_ctl_t;
  typedef struct packed {
    logic awvalid; logic [AXI_AW-1:0] awaddr;
    logic wvalid;  logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [AXI_AW-1:0] araddr;
    logic rready;
  } stbt_axi_req_t;
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid;  logic [1:0] bresp;
    logic arready;
    logic rvalid;  logic [31:0] rdata; logic [1:0] rresp;
  } stbt_axi_rsp_t;
  typedef struct packed {
    logic tck_s1; logic tck_s2; logic tck_d;
    logic tms_s1; logic tms_s2; logic tdi_s1; logic tdi_s2;
    logic [BUS_W-1:0] a_s1; logic [BUS_W-1:0] a_s2;
    logic [BUS_W-1:0] b_s1; logic [BUS_W-1:0] b_s2;
    stbt_ctl_t ctl_s1; stbt_ctl_t ctl_s2; logic [3:0] ck_d;
    logic [BUS_W-1:0] ab_q; logic [BUS_W-1:0] ba_q;
    logic [BUS_W-1:0] ao; logic [BUS_W-1:0] aoe;
    logic [BUS_W-1:0] bo; logic [BUS_W-1:0] boe;
    stbt_tap_t tap; logic [2:0] hi_cnt;
    logic [IR_W-1:0] ir_sh; logic [IR_W-1:0] ir;
    logic [BSR_W-1:0] bsr_sh; logic [BSR_W-1:0] bsr_up;
    logic [BCR_W-1:0] bcr_sh; logic [BCR_W-1:0] bcr;
    logic byp; logic [ID_W-1:0] id_sh;
    logic tdo; logic tdo_oe;
    logic hold_rst;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } stbt_state_t;
endpackage

// ===== verilog/stbt_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
// Contract
// - latch enable high passes a to b
// - latch low, steady clock holds b
// - latch low stores a on clock rise
// - enable low drives b, high floats
// - b to a path mirrors a to b
// - two independent nine-bit halves
// - test port idle leaves data flow
// - test mode owns every boundary cell
// - pin snapshot and boundary self test
// - signature compression and random patterns
// - binary count and sample-toggle modes
// - standard plus clamp, highz; even parity
// - test state machine uses tck, tms only; software hold also forces reset state
// - sample on tck rise, tdo on fall
// - controller steers tms, shifts tdi/tdo
// - instruction register eight bits
// - chains of 48, 3, 1, 32 bits
// - reset values 10000001 and 010
// - five tms-high clocks reach reset state
// - reset sets enable cells 47 to 44
// - control operations run only in idle
module stbt_top #(
  parameter logic [31:0] ID_CODE = 32'h0000_0c01  // arbitrary value
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // a port
  input  wire logic [stbt_pkg::BUS_W-1:0]     a_in,
  output logic [stbt_pkg::BUS_W-1:0]          a_out,
  output logic [stbt_pkg::BUS_W-1:0]          a_oe,
  // b port
  input  wire logic [stbt_pkg::BUS_W-1:0]     b_in,
  output logic [stbt_pkg::BUS_W-1:0]          b_out,
  output logic [stbt_pkg::BUS_W-1:0]          b_oe,
  // per-half controls
  input  wire stbt_pkg::stbt_ctl_t            half_ctl,
  // test access port
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  output logic                                tdo,
  output logic                                tdo_oe,
  // register bus
  input  wire stbt_pkg::stbt_axi_req_t        axi_req,
  output stbt_pkg::stbt_axi_rsp_t             axi_rsp
);
  import stbt_pkg::*;

  stbt_state_t      s_reg;
  stbt_state_t      s_next;
  logic             tck_rise;
  logic             tck_fall;
  logic             test_mode;
  logic             sel_bsr;
  logic             sel_bcr;
  logic             sel_id;
  logic [BSR_W-1:0] pins;
  logic             wr_go;
  logic             rd_go;

  // ==========================================================
  // tap next state
  function automatic stbt_tap_t tap_step(stbt_tap_t st, logic m);
    case (st)
      TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:  tap_step = m ? TAP_SDR : TAP_IDLE;
      TAP_SDR:   tap_step = m ? TAP_SIR : TAP_CDR;
      TAP_CDR:   tap_step = m ? TAP_E1DR : TAP_SHDR;
      TAP_SHDR:  tap_step = m ? TAP_E1DR : TAP_SHDR;
      TAP_E1DR:  tap_step = m ? TAP_UDR : TAP_PDR;
      TAP_PDR:   tap_step = m ? TAP_E2DR : TAP_PDR;
      TAP_E2DR:  tap_step = m ? TAP_UDR : TAP_SHDR;
      TAP_UDR:   tap_step = m ? TAP_SDR : TAP_IDLE;
      TAP_SIR:   tap_step = m ? TAP_RESET : TAP_CIR;
      TAP_CIR:   tap_step = m ? TAP_E1IR : TAP_SHIR;
      TAP_SHIR:  tap_step = m ? TAP_E1IR : TAP_SHIR;
      TAP_E1IR:  tap_step = m ? TAP_UIR : TAP_PIR;
      TAP_PIR:   tap_step = m ? TAP_E2IR : TAP_PIR;
      TAP_E2IR:  tap_step = m ? TAP_UIR : TAP_SHIR;
      TAP_UIR:   tap_step = m ? TAP_SDR : TAP_IDLE;
      default:   tap_step = TAP_RESET;
    endcase
  endfunction

  // ==========================================================
  // decode
  // tck edges seen from second and third flops only
  assign tck_rise = s_reg.tck_s2 & ~s_reg.tck_d;
  assign tck_fall = ~s_reg.tck_s2 & s_reg.tck_d;
  assign test_mode = (s_reg.ir == OP_EXTEST) || (s_reg.ir == OP_CLAMP)
                  || (s_reg.ir == OP_HIGHZ) || (s_reg.ir == OP_RUNT);
  assign sel_bsr = (s_reg.ir == OP_EXTEST) || (s_reg.ir == OP_SAMPLE)
                || (s_reg.ir == OP_RUNT);
  assign sel_bcr = (s_reg.ir == OP_BCRSC);
  assign sel_id  = (s_reg.ir == OP_IDCODE);
  assign pins = {s_reg.ctl_s2[1].a_to_b_output_enable_n, s_reg.ctl_s2[0].a_to_b_output_enable_n,
                 s_reg.ctl_s2[1].b_to_a_output_enable_n, s_reg.ctl_s2[0].b_to_a_output_enable_n,
                 s_reg.ctl_s2[1].a_to_b_latch_enable, s_reg.ctl_s2[0].a_to_b_latch_enable,
                 s_reg.ctl_s2[1].b_to_a_latch_enable, s_reg.ctl_s2[0].b_to_a_latch_enable,
                 s_reg.ctl_s2[1].a_to_b_clock, s_reg.ctl_s2[0].a_to_b_clock,
                 s_reg.ctl_s2[1].b_to_a_clock, s_reg.ctl_s2[0].b_to_a_clock,
                 s_reg.b_s2, s_reg.a_s2};
  // write takes address and data together
  assign wr_go = axi_req.awvalid && axi_req.wvalid && !s_reg.bvalid;
  assign rd_go = axi_req.arvalid && !s_reg.rvalid;

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    // synchronisers
    s_next.tck_s1 = tck;
    s_next.tck_s2 = s_reg.tck_s1;
    s_next.tck_d  = s_reg.tck_s2;
    s_next.tms_s1 = tms;
    s_next.tms_s2 = s_reg.tms_s1;
    s_next.tdi_s1 = tdi;
    s_next.tdi_s2 = s_reg.tdi_s1;
    s_next.a_s1   = a_in;
    s_next.a_s2   = s_reg.a_s1;
    s_next.b_s1   = b_in;
    s_next.b_s2   = s_reg.b_s1;
    s_next.ctl_s1 = half_ctl;
    s_next.ctl_s2 = s_reg.ctl_s1;
    s_next.ck_d   = {s_reg.ctl_s2[1].b_to_a_clock, s_reg.ctl_s2[0].b_to_a_clock,
                     s_reg.ctl_s2[1].a_to_b_clock, s_reg.ctl_s2[0].a_to_b_clock};
    // each half on its own controls
    for (int h = 0; h < 2; h++)
    begin
      // latches run only outside test mode
      if (!test_mode)
      begin
        if (s_reg.ctl_s2[h].a_to_b_latch_enable
            || (s_reg.ctl_s2[h].a_to_b_clock && !s_reg.ck_d[h]))
          s_next.ab_q[h*HALF_W +: HALF_W] = s_reg.a_s2[h*HALF_W +: HALF_W];
        if (s_reg.ctl_s2[h].b_to_a_latch_enable
            || (s_reg.ctl_s2[h].b_to_a_clock && !s_reg.ck_d[h+2]))
          s_next.ba_q[h*HALF_W +: HALF_W] = s_reg.b_s2[h*HALF_W +: HALF_W];
      end
      if (test_mode)
      begin
        s_next.boe[h*HALF_W +: HALF_W] = {HALF_W{~s_reg.bsr_up[BSR_AB_OE+h]}};
        s_next.aoe[h*HALF_W +: HALF_W] = {HALF_W{~s_reg.bsr_up[BSR_BA_OE+h]}};
      end
      else
      begin
        s_next.boe[h*HALF_W +: HALF_W] = {HALF_W{~s_reg.ctl_s2[h].a_to_b_output_enable_n}};
        s_next.aoe[h*HALF_W +: HALF_W] = {HALF_W{~s_reg.ctl_s2[h].b_to_a_output_enable_n}};
      end
    end
    // boundary cells drive pins in test mode
    s_next.bo = test_mode ? s_reg.bsr_up[BSR_B_LSB +: BUS_W] : s_reg.ab_q;
    s_next.ao = test_mode ? s_reg.bsr_up[BUS_W-1:0] : s_reg.ba_q;
    if (s_reg.ir == OP_HIGHZ)
    begin
      s_next.boe = '0;
      s_next.aoe = '0;
    end
    if (tck_rise)
    begin
      case (s_reg.tap)
        TAP_CIR:  s_next.ir_sh = IR_RESET;
        TAP_SHIR: s_next.ir_sh = {s_reg.tdi_s2, s_reg.ir_sh[IR_W-1:1]};
        TAP_CDR:
        begin
          if (sel_bsr)
            s_next.bsr_sh = pins;
          s_next.bcr_sh = s_reg.bcr;
          s_next.id_sh  = ID_CODE;
          s_next.byp    = 1'b0;
        end
        TAP_SHDR:
        begin
          if (sel_bsr)
            s_next.bsr_sh = {s_reg.tdi_s2, s_reg.bsr_sh[BSR_W-1:1]};
          else if (sel_bcr)
            s_next.bcr_sh = {s_reg.tdi_s2, s_reg.bcr_sh[BCR_W-1:1]};
          else if (sel_id)
            s_next.id_sh = {s_reg.tdi_s2, s_reg.id_sh[ID_W-1:1]};
          else
            s_next.byp = s_reg.tdi_s2;
        end
        TAP_IDLE:
        begin
          if (s_reg.ir == OP_RUNT)
          begin
            case (s_reg.bcr)
              BC_PSA: s_next.bsr_sh[DATA_W-1:0] = {s_reg.bsr_sh[DATA_W-2:0],
                        s_reg.bsr_sh[DATA_W-1] ^ s_reg.bsr_sh[LFSR_TAP]} ^ pins[DATA_W-1:0];
              BC_PSEUDO_RANDOM_PATTERN_GEN: s_next.bsr_up[DATA_W-1:0] = {s_reg.bsr_up[DATA_W-2:0],
                        s_reg.bsr_up[DATA_W-1] ^ s_reg.bsr_up[LFSR_TAP]
                        ^ (s_reg.bsr_up[DATA_W-1:0] == '0)};
              BC_COUNT: s_next.bsr_up[DATA_W-1:0] = s_reg.bsr_up[DATA_W-1:0] + 1'b1;
              BC_TOGGLE:
              begin
                s_next.bsr_up[DATA_W-1:0] = ~s_reg.bsr_up[DATA_W-1:0];
                s_next.bsr_sh[DATA_W-1:0] = pins[DATA_W-1:0];
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
      s_next.tap    = tap_step(s_reg.tap, s_reg.tms_s2);
      s_next.hi_cnt = !s_reg.tms_s2 ? 3'h0 : (s_reg.hi_cnt == HI_CNT) ? HI_CNT
                                           : s_reg.hi_cnt + 3'h1;
    end
    // tdo and updates on tck fall
    if (tck_fall)
    begin
      s_next.tdo_oe = (s_reg.tap == TAP_SHIR) || (s_reg.tap == TAP_SHDR);
      if (s_reg.tap == TAP_SHIR)
        s_next.tdo = s_reg.ir_sh[0];
      else if (sel_bsr)
        s_next.tdo = s_reg.bsr_sh[0];
      else if (sel_bcr)
        s_next.tdo = s_reg.bcr_sh[0];
      else if (sel_id)
        s_next.tdo = s_reg.id_sh[0];
      else
        s_next.tdo = s_reg.byp;
      // odd-parity opcodes fall back to bypass
      if (s_reg.tap == TAP_UIR)
        s_next.ir = (^s_reg.ir_sh) ? OP_BYPASS : s_reg.ir_sh;
      if (s_reg.tap == TAP_UDR && sel_bsr)
        s_next.bsr_up = s_reg.bsr_sh;
      if (s_reg.tap == TAP_UDR && sel_bcr)
        s_next.bcr = s_reg.bcr_sh;
    end
    // software may hold the test logic in reset
    if (s_reg.hold_rst)
      s_next.tap = TAP_RESET;
    if (s_reg.tap == TAP_RESET)
    begin
      s_next.ir                      = IR_RESET;
      s_next.bcr                     = BCR_RESET;
      s_next.bsr_up[BSR_W-1 -: 4]    = OE_RESET;
      s_next.bsr_sh[BSR_W-1 -: 4]    = OE_RESET;
    end
    // register bus, answers clear before new requests
    if (s_reg.bvalid && axi_req.bready)
      s_next.bvalid = 1'b0;
    if (s_reg.rvalid && axi_req.rready)
      s_next.rvalid = 1'b0;
    if (wr_go)
    begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (axi_req.awaddr == ADDR_CTRL && axi_req.wstrb[0])
        s_next.hold_rst = axi_req.wdata[0];
      else if (axi_req.awaddr != ADDR_CTRL && axi_req.awaddr != ADDR_STATUS)
        s_next.bresp = RESP_SLVERR;
    end
    if (rd_go)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      if (axi_req.araddr == ADDR_STATUS)
        s_next.rdata = 32'({test_mode, s_reg.bcr, s_reg.ir, s_reg.tap});
      else if (axi_req.araddr == ADDR_CTRL)
        s_next.rdata = 32'(s_reg.hold_rst);
      else
      begin
        s_next.rdata = '0;
        s_next.rresp = RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_reg         <= '0;
      s_reg.tap     <= TAP_RESET;
      s_reg.ir      <= IR_RESET;
      s_reg.bcr     <= BCR_RESET;
      s_reg.bsr_up  <= {OE_RESET, {(BSR_W-4){1'b0}}};
      s_reg.bsr_sh  <= {OE_RESET, {(BSR_W-4){1'b0}}};
    end
    else
      s_reg <= s_next;
  end

  // outputs
  assign a_out  = s_reg.ao;
  assign a_oe   = s_reg.aoe;
  assign b_out  = s_reg.bo;
  assign b_oe   = s_reg.boe;
  assign tdo    = s_reg.tdo;
  assign tdo_oe = s_reg.tdo_oe;
  assign axi_rsp = '{awready: wr_go, wready: wr_go, bvalid: s_reg.bvalid,
                     bresp: s_reg.bresp, arready: !s_reg.rvalid, rvalid: s_reg.rvalid,
                     rdata: s_reg.rdata, rresp: s_reg.rresp};

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_transp;
    !test_mode && s_reg.ctl_s2[0].a_to_b_latch_enable;
  endsequence
  sequence s_in_reset;
    s_reg.tap == TAP_RESET;
  endsequence

  property p_transp;
    s_transp |=> s_reg.ab_q[8:0] == $past(s_reg.a_s2[8:0]);
  endproperty
  a_transp: assert property (p_transp) else $error("a to b not transparent");

  property p_hold;
    !test_mode && !s_reg.ctl_s2[0].a_to_b_latch_enable
      && !(s_reg.ctl_s2[0].a_to_b_clock && !s_reg.ck_d[0]) |=> $stable(s_reg.ab_q[8:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("latched data changed");

  property p_clk_cap;
    !test_mode && !s_reg.ctl_s2[1].a_to_b_latch_enable
      && s_reg.ctl_s2[1].a_to_b_clock && !s_reg.ck_d[1]
      |=> s_reg.ab_q[17:9] == $past(s_reg.a_s2[17:9]);
  endproperty
  a_clk_cap: assert property (p_clk_cap) else $error("clock edge missed");

  property p_oe_off;
    !test_mode && s_reg.ctl_s2[0].a_to_b_output_enable_n |=> b_oe[8:0] == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("b driven while disabled");

  property p_highz;
    s_reg.ir == OP_HIGHZ |=> a_oe == '0 && b_oe == '0;
  endproperty
  a_highz: assert property (p_highz) else $error("pins driven under highz");

  property p_parity;
    !(^s_reg.ir);
  endproperty
  a_parity: assert property (p_parity) else $error("odd-parity opcode held");

  property p_tdo_fall;
    $changed(tdo) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling tck");

  property p_reset_vals;
    s_in_reset |=> s_reg.ir == IR_RESET && s_reg.bcr == BCR_RESET
                   && s_reg.bsr_up[BSR_W-1 -: 4] == OE_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_five;
    s_reg.hi_cnt == HI_CNT |-> s_in_reset;
  endproperty
  a_five: assert property (p_five) else $error("five tms highs missed reset");
endmodule
